// >>> logic/dtc_pkg.sv
// Constants, types and field layout of the dual timer/counter block
// Functional notes
// - Control byte: flags 7,5; run bits 6,4
// - Run bit low stops, high enables
// - Source select at mode bits 2 and 6
// - Internal tick: oscillator/12 on third phase
// - External source: each counter its own pin
// - Falling edge captured, synced at S5, ANDed S3
// - Power-down feeds pin edges straight through
// - Pin counting continues; carry ends power-down
// - Gate enables at mode bits 3 and 7
// - Gate low: run bit alone decides
// - Gate high: run bit and irq pin
// - Two independent 16-bit readable writable counters
// - Mode fields at bits 1:0 and 5:4
// - Mode 0 13-bit, mode 1 16-bit, carry flags
// - Mode 2: low byte reloads from high
// - Mode 3 splits counter 0, stops counter 1
package dtc_pkg;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
	localparam logic [7:0] IDX_COUNT0_LOW = 8'h8A;
	localparam logic [7:0] IDX_COUNT0_HIGH = 8'h8B;
	localparam logic [7:0] IDX_COUNT1_LOW = 8'h8C;
	localparam logic [7:0] IDX_COUNT1_HIGH = 8'h8D;
	localparam logic [7:0] IDX_POWER_CONTROL = 8'h8E;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h8F;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h90;

	// ==========================================================
	// Field positions
	localparam int TC_OVF1 = 7;
	localparam int TC_RUN1 = 6;
	localparam int TC_OVF0 = 5;
	localparam int TC_RUN0 = 4;
	localparam int TM_CFG1_LSB = 4;
	localparam int TM_CFG0_LSB = 0;
	localparam int PC_SOFT = 0;
	localparam int PC_HARD = 1;
	localparam int IRQ_OVF0 = 0;
	localparam int IRQ_OVF1 = 1;
	localparam int IRQ_WAKE = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_POWER = 2'h0;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// ==========================================================
	// Timing: one machine cycle is twelve oscillator periods
	localparam int MACHINE_PHASES = 12;
	localparam int PHASE_S3 = 4;
	localparam int PHASE_S5 = 8;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPLIT
	} dtc_mode_e;

	typedef struct packed {
		logic gate;
		logic ext_src;
		logic mode_select_high;
		logic mode_select_low;
	} dtc_cfg_s;

	typedef struct packed {
		logic carry;
		logic [7:0] high;
		logic [7:0] low;
	} dtc_count_s;

endpackage

// >>> logic/dtc_phase_gen.sv
// State phase strobes of the machine cycle
`timescale 1ns/1ps
module dtc_phase_gen #(
	parameter int PHASES = dtc_pkg::MACHINE_PHASES,
	parameter int S3 = dtc_pkg::PHASE_S3,
	parameter int S5 = dtc_pkg::PHASE_S5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic halt,
	output logic third_state_phase,
	output logic fifth_state_phase
);

	// Elaboration check of phase positions
	if (PHASES < 9 || PHASES > 16 ||
		S3 >= PHASES || S5 >= PHASES) begin : g_bad
		$error("dtc_phase_gen: phase parameters out of range");
	end

	localparam logic [3:0] LAST = 4'(PHASES - 1);
	localparam logic [3:0] P3 = 4'(S3);
	localparam logic [3:0] P5 = 4'(S5);

	logic [3:0] ph_q;

	// Phase counter frozen while the oscillator is stopped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_q <= 4'h0;
			third_state_phase <= 1'b0;
			fifth_state_phase <= 1'b0;
		end else begin
			if (!halt) begin
				ph_q <= (ph_q == LAST) ? 4'h0 : ph_q + 4'h1;
			end
			third_state_phase <= !halt && (ph_q == P3);
			fifth_state_phase <= !halt && (ph_q == P5);
		end
	end

	property p_s3_spacing;
		@(posedge aclk) disable iff (!aresetn)
		third_state_phase |=> !third_state_phase [*8];
	endproperty
	a_s3_spacing: assert property (p_s3_spacing)
		else $error("third phase strobes too close");

endmodule

// >>> logic/dtc_ext_detect.sv
// External count pin synchroniser and falling-edge detector
`timescale 1ns/1ps
module dtc_ext_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire logic third_state_phase,
	input wire logic fifth_state_phase,
	input wire logic bypass,
	output logic pulse
);

	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic edge_capture_flop_q;
	logic phase_sync_flop_q;
	wire fall = prev_q & ~sync_q;
	wire phase_pulse = phase_sync_flop_q & third_state_phase;

	// Normal path through the two flops, or the raw edge in power-down
	assign pulse = bypass ? fall : phase_pulse;

	// Pin synchroniser and edge flops; a new edge wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
			edge_capture_flop_q <= 1'b0;
			phase_sync_flop_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
			// Relies on 12-period pin phases for sampling
			edge_capture_flop_q <= !bypass &&
				(fall || (edge_capture_flop_q && !phase_pulse));
			if (fifth_state_phase) begin
				phase_sync_flop_q <= edge_capture_flop_q;
			end
		end
	end

	property p_edge_to_count;
		@(posedge aclk) disable iff (!aresetn)
		(fall && !bypass) |-> ##[1:25] (pulse || bypass);
	endproperty
	a_edge_to_count: assert property (p_edge_to_count)
		else $error("pin edge did not yield a count pulse");

endmodule

// >>> logic/dtc_timer.sv
// Dual timer/counter with AXI4-Lite register access
`timescale 1ns/1ps
module dtc_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	output logic soft_power_down,
	output logic hard_power_down,
	output logic irq
);

	// ==========================================================
	// Helper functions

	// Word address match against a register index
	function automatic logic hit(logic [11:0] addr, logic [7:0] idx);
		return addr[11:2] == {2'h0, idx};
	endfunction

	// Any register of the map
	function automatic logic mapped(logic [11:0] addr);
		return addr[11:2] >= {2'h0, dtc_pkg::IDX_TIMER_CONTROL} &&
			addr[11:2] <= {2'h0, dtc_pkg::IDX_IRQ_MASK};
	endfunction

	// One count step of a counter in the given mode
	function automatic dtc_pkg::dtc_count_s count_step(
		dtc_pkg::dtc_mode_e m,
		logic [7:0] lo,
		logic [7:0] hi
	);
		dtc_pkg::dtc_count_s r;
		logic [16:0] w;
		r = '{carry: 1'b0, high: hi, low: lo};
		w = 17'h00000;
		case (m)
			dtc_pkg::MODE_13BIT: begin
				w = {4'h0, hi, lo[4:0]} + 17'h00001;
				r.low = {lo[7:5], w[4:0]};
				r.high = w[12:5];
				r.carry = w[13];
			end
			dtc_pkg::MODE_16BIT: begin
				w = {1'b0, hi, lo} + 17'h00001;
				r.low = w[7:0];
				r.high = w[15:8];
				r.carry = w[16];
			end
			dtc_pkg::MODE_RELOAD: begin
				r.carry = (lo == 8'hFF);
				r.low = r.carry ? hi : lo + 8'h01;
			end
			default: begin
				r.carry = (lo == 8'hFF);
				r.low = lo + 8'h01;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// Registers
	logic [7:0] timer_control_q;
	logic [7:0] timer_mode_q;
	logic [7:0] c0_lo_q;
	logic [7:0] c0_hi_q;
	logic [7:0] c1_lo_q;
	logic [7:0] c1_hi_q;
	logic [1:0] power_q;
	logic [2:0] irq_status_q;
	logic [2:0] irq_mask_q;
	logic ext_irq_pin_zero_meta_q;
	logic ext_irq_pin_zero_q;
	logic ext_irq_pin_one_meta_q;
	logic ext_irq_pin_one_q;

	// Bus state
	logic aw_held_q;
	logic w_held_q;
	logic [11:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;

	// ==========================================================
	// AXI4-Lite write path
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
	wire wr_en = do_write & wstrb0_q;
	wire aw_held_d = aw_held_q ? ~do_write : aw_hs;
	wire w_held_d = w_held_q ? ~do_write : w_hs;
	wire bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);

	// Per-register write strobes
	wire wr_tc = wr_en & hit(awaddr_q, dtc_pkg::IDX_TIMER_CONTROL);
	wire wr_tm = wr_en & hit(awaddr_q, dtc_pkg::IDX_TIMER_MODE);
	wire wr_c0l = wr_en & hit(awaddr_q, dtc_pkg::IDX_COUNT0_LOW);
	wire wr_c0h = wr_en & hit(awaddr_q, dtc_pkg::IDX_COUNT0_HIGH);
	wire wr_c1l = wr_en & hit(awaddr_q, dtc_pkg::IDX_COUNT1_LOW);
	wire wr_c1h = wr_en & hit(awaddr_q, dtc_pkg::IDX_COUNT1_HIGH);
	wire wr_pc = wr_en & hit(awaddr_q, dtc_pkg::IDX_POWER_CONTROL);
	wire wr_is = wr_en & hit(awaddr_q, dtc_pkg::IDX_IRQ_STATUS);
	wire wr_im = wr_en & hit(awaddr_q, dtc_pkg::IDX_IRQ_MASK);

	// Address and data holding, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= dtc_pkg::RST_BYTE;
			wstrb0_q <= 1'b0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_q <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
		end
	end

	// Write handshake outputs and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dtc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held_d;
			s_axi_wready <= ~w_held_d;
			s_axi_bvalid <= bvalid_d;
			if (do_write) begin
				s_axi_bresp <= mapped(awaddr_q) ? dtc_pkg::RESP_OKAY :
					dtc_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire [11:0] ra = s_axi_araddr;
	wire [7:0] rd_byte =
		hit(ra, dtc_pkg::IDX_TIMER_CONTROL) ? timer_control_q :
		hit(ra, dtc_pkg::IDX_TIMER_MODE) ? timer_mode_q :
		hit(ra, dtc_pkg::IDX_COUNT0_LOW) ? c0_lo_q :
		hit(ra, dtc_pkg::IDX_COUNT0_HIGH) ? c0_hi_q :
		hit(ra, dtc_pkg::IDX_COUNT1_LOW) ? c1_lo_q :
		hit(ra, dtc_pkg::IDX_COUNT1_HIGH) ? c1_hi_q :
		hit(ra, dtc_pkg::IDX_POWER_CONTROL) ? {6'h00, power_q} :
		hit(ra, dtc_pkg::IDX_IRQ_STATUS) ? {5'h00, irq_status_q} :
		hit(ra, dtc_pkg::IDX_IRQ_MASK) ? {5'h00, irq_mask_q} :
		8'h00;

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= dtc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
			if (ar_hs) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= mapped(ra) ? dtc_pkg::RESP_OKAY :
					dtc_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Phase strobes and pin detectors
	logic s3;
	logic s5;
	logic ext0_pulse;
	logic ext1_pulse;
	wire pd = |power_q;

	// Oscillator stops in either power-down state
	dtc_phase_gen u_phase (
		.aclk(aclk),
		.aresetn(aresetn),
		.halt(pd),
		.third_state_phase(s3),
		.fifth_state_phase(s5)
	);

	dtc_ext_detect u_det0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(count_pin_zero),
		.third_state_phase(s3),
		.fifth_state_phase(s5),
		.bypass(pd),
		.pulse(ext0_pulse)
	);

	dtc_ext_detect u_det1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(count_pin_one),
		.third_state_phase(s3),
		.fifth_state_phase(s5),
		.bypass(pd),
		.pulse(ext1_pulse)
	);

	// ==========================================================
	// Count control
	wire dtc_pkg::dtc_cfg_s cfg0 = timer_mode_q[dtc_pkg::TM_CFG0_LSB +: 4];
	wire dtc_pkg::dtc_cfg_s cfg1 = timer_mode_q[dtc_pkg::TM_CFG1_LSB +: 4];
	wire dtc_pkg::dtc_mode_e mode0 = dtc_pkg::dtc_mode_e'(
		{cfg0.mode_select_high, cfg0.mode_select_low});
	wire dtc_pkg::dtc_mode_e mode1 = dtc_pkg::dtc_mode_e'(
		{cfg1.mode_select_high, cfg1.mode_select_low});
	wire run_bit_zero = timer_control_q[dtc_pkg::TC_RUN0];
	wire run_bit_one = timer_control_q[dtc_pkg::TC_RUN1];
	wire split0 = (mode0 == dtc_pkg::MODE_SPLIT);

	// Run bit, qualified by the irq pin only when gated
	wire en0 = run_bit_zero & (~cfg0.gate | ext_irq_pin_zero_q);
	wire en1 = run_bit_one & (~cfg1.gate | ext_irq_pin_one_q) & ~split0 &
		(mode1 != dtc_pkg::MODE_SPLIT);

	// Tick source: machine cycle or the own pin
	// Strobe is registered and lags the halt one edge, so mask it here
	wire s3_run = s3 & ~pd;
	wire tick0 = en0 & (cfg0.ext_src ? ext0_pulse : s3_run);
	wire tick1 = en1 & (cfg1.ext_src ? ext1_pulse : s3_run);
	wire tick0h = split0 & run_bit_one & s3_run;

	wire dtc_pkg::dtc_count_s step0 = count_step(mode0, c0_lo_q, c0_hi_q);
	wire dtc_pkg::dtc_count_s step1 = count_step(mode1, c1_lo_q, c1_hi_q);
	wire carry0 = tick0 & step0.carry;
	wire carry0h = tick0h & (c0_hi_q == 8'hFF);
	wire carry1 = (tick1 & step1.carry) | carry0h;

	// Carry during power-down wakes the processor
	wire wake = pd & (carry0 | carry1);

	// ==========================================================
	// Counter next values; a software write beats a count
	wire [7:0] c0_lo_d = wr_c0l ? wdata_q : tick0 ? step0.low : c0_lo_q;
	wire [7:0] c0_hi_d = wr_c0h ? wdata_q :
		tick0h ? c0_hi_q + 8'h01 :
		tick0 ? step0.high : c0_hi_q;
	wire [7:0] c1_lo_d = wr_c1l ? wdata_q : tick1 ? step1.low : c1_lo_q;
	wire [7:0] c1_hi_d = wr_c1h ? wdata_q : tick1 ? step1.high : c1_hi_q;

	// Control byte with flags; a carry wins over a clearing write
	wire [7:0] tc_base = wr_tc ? wdata_q : timer_control_q;
	wire [7:0] tc_d = tc_base |
		(8'(carry1) << dtc_pkg::TC_OVF1) |
		(8'(carry0) << dtc_pkg::TC_OVF0);

	wire [1:0] power_d = wake ? 2'h0 : wr_pc ? wdata_q[1:0] : power_q;
	wire [2:0] events = {wake, carry1, carry0};
	wire [2:0] irq_clear = wr_is ? wdata_q[2:0] : 3'h0;
	wire [2:0] irq_status_d = (irq_status_q & ~irq_clear) | events;

	// Counter registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c0_lo_q <= dtc_pkg::RST_BYTE;
			c0_hi_q <= dtc_pkg::RST_BYTE;
			c1_lo_q <= dtc_pkg::RST_BYTE;
			c1_hi_q <= dtc_pkg::RST_BYTE;
		end else begin
			c0_lo_q <= c0_lo_d;
			c0_hi_q <= c0_hi_d;
			c1_lo_q <= c1_lo_d;
			c1_hi_q <= c1_hi_d;
		end
	end

	// Control, power and interrupt registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control_q <= dtc_pkg::RST_BYTE;
			timer_mode_q <= dtc_pkg::RST_BYTE;
			power_q <= dtc_pkg::RST_POWER;
			irq_status_q <= dtc_pkg::RST_IRQ;
			irq_mask_q <= dtc_pkg::RST_IRQ;
		end else begin
			timer_control_q <= tc_d;
			timer_mode_q <= wr_tm ? wdata_q : timer_mode_q;
			power_q <= power_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= wr_im ? wdata_q[2:0] : irq_mask_q;
		end
	end

	// Gate pin synchronisers and registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq_pin_zero_meta_q <= 1'b0;
			ext_irq_pin_zero_q <= 1'b0;
			ext_irq_pin_one_meta_q <= 1'b0;
			ext_irq_pin_one_q <= 1'b0;
			soft_power_down <= 1'b0;
			hard_power_down <= 1'b0;
			irq <= 1'b0;
		end else begin
			ext_irq_pin_zero_meta_q <= ext_irq_pin_zero;
			ext_irq_pin_zero_q <= ext_irq_pin_zero_meta_q;
			ext_irq_pin_one_meta_q <= ext_irq_pin_one;
			ext_irq_pin_one_q <= ext_irq_pin_one_meta_q;
			soft_power_down <= power_d[dtc_pkg::PC_SOFT];
			hard_power_down <= power_d[dtc_pkg::PC_HARD];
			irq <= |(irq_status_d & irq_mask_q);
		end
	end

	// ==========================================================
	// Assertions
	property p_stop;
		@(posedge aclk) disable iff (!aresetn)
		(!run_bit_zero && !split0 && !wr_c0l && !wr_c0h)
			|=> $stable({c0_hi_q, c0_lo_q});
	endproperty
	a_stop: assert property (p_stop)
		else $error("counter 0 moved while stopped");

	property p_gate_hold;
		@(posedge aclk) disable iff (!aresetn)
		(cfg0.gate && !ext_irq_pin_zero_q && !split0 && !wr_c0l && !wr_c0h)
			|=> $stable({c0_hi_q, c0_lo_q});
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gated counter 0 moved with pin low");

	property p_int_source;
		@(posedge aclk) disable iff (!aresetn)
		(tick0 && !cfg0.ext_src) |-> s3 && !pd;
	endproperty
	a_int_source: assert property (p_int_source)
		else $error("internal tick off the third phase");

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		carry0 |=> timer_control_q[dtc_pkg::TC_OVF0];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("overflow flag zero not set on carry");

	property p_reload;
		@(posedge aclk) disable iff (!aresetn)
		(tick0 && mode0 == dtc_pkg::MODE_RELOAD && c0_lo_q == 8'hFF &&
			!wr_c0l) |=> c0_lo_q == $past(c0_hi_q);
	endproperty
	a_reload: assert property (p_reload)
		else $error("mode 2 did not reload from high byte");

	property p_split_stop;
		@(posedge aclk) disable iff (!aresetn)
		(split0 && !wr_c1l && !wr_c1h) |=> $stable({c1_hi_q, c1_lo_q});
	endproperty
	a_split_stop: assert property (p_split_stop)
		else $error("counter 1 ran while counter 0 split");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		(pd && (carry0 || carry1)) |=> !soft_power_down && !hard_power_down
			&& irq_status_q[dtc_pkg::IRQ_WAKE];
	endproperty
	a_wake: assert property (p_wake)
		else $error("carry did not end power-down");

	property p_mode13;
		@(posedge aclk) disable iff (!aresetn)
		(tick0 && mode0 == dtc_pkg::MODE_13BIT && !wr_c0l && !wr_c0h &&
			!tick0h) |=> c0_lo_q[7:5] == $past(c0_lo_q[7:5]);
	endproperty
	a_mode13: assert property (p_mode13)
		else $error("13-bit mode touched upper low bits");

	c_reload: cover property (@(posedge aclk) disable iff (!aresetn)
		tick0 && mode0 == dtc_pkg::MODE_RELOAD && step0.carry);
	c_split_carry: cover property (@(posedge aclk) disable iff (!aresetn)
		carry0h);
	c_wake: cover property (@(posedge aclk) disable iff (!aresetn)
		wake);
	c_ext_count: cover property (@(posedge aclk) disable iff (!aresetn)
		tick1 && cfg1.ext_src);

endmodule

// >>> tb/dtc_pin_model.sv
// Pin-side partner: count pulse source and gate levels
`timescale 1ns/1ps
module dtc_pin_model (
	input wire logic aclk,
	input wire logic [1:0] gate,
	output logic count_pin_zero,
	output logic count_pin_one,
	output logic ext_irq_pin_zero,
	output logic ext_irq_pin_one
);
	logic [1:0] cp;

	// ==========================================================
	// Pin drive
	// Separate count pin per counter, gates follow the bench
	assign count_pin_zero = cp[0];
	assign count_pin_one = cp[1];
	assign ext_irq_pin_zero = gate[0];
	assign ext_irq_pin_one = gate[1];

	// Count pins idle high so no stray falling edge appears
	initial begin
		cp = 2'h3;
	end

	// Low and high phases each last half clocks, never under 12
	task automatic pulses(input int ch, input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge aclk);
			cp[ch] <= 1'h0;
			repeat (half) @(posedge aclk);
			cp[ch] <= 1'h1;
		end
	endtask
endmodule

// >>> tb/dtc_timer_tb.sv
// Self-checking bench of the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_tb;
	localparam logic [11:0] TC = {2'h0, dtc_pkg::IDX_TIMER_CONTROL, 2'h0};
	localparam logic [11:0] TM = {2'h0, dtc_pkg::IDX_TIMER_MODE, 2'h0};
	localparam logic [11:0] C0L = {2'h0, dtc_pkg::IDX_COUNT0_LOW, 2'h0};
	localparam logic [11:0] PC = {2'h0, dtc_pkg::IDX_POWER_CONTROL, 2'h0};
	localparam logic [11:0] IS = {2'h0, dtc_pkg::IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] IM = {2'h0, dtc_pkg::IDX_IRQ_MASK, 2'h0};
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rv, cf;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, gate;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, count_pin_zero, count_pin_one;
	logic ext_irq_pin_zero, ext_irq_pin_one, irq;
	logic soft_power_down, hard_power_down;
	logic [7:0] rb;
	int fail_count, num_checks, oth;

	dtc_timer i_dtc_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_pin_zero,
		.count_pin_one, .ext_irq_pin_zero, .ext_irq_pin_one,
		.soft_power_down, .hard_power_down, .irq);
	dtc_pin_model i_dtc_pin_model (.aclk, .gate, .count_pin_zero,
		.count_pin_one, .ext_irq_pin_zero, .ext_irq_pin_one);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Byte address of a counter's low or high byte
	function automatic logic [11:0] ca(input int ch, input int hi);
		return C0L + 12'(8 * ch + 4 * hi);
	endfunction

	// Fewest internal ticks while go() holds the run bit for w clocks
	function automatic logic [31:0] ticks(input int w);
		return 32'((w + 7) / dtc_pkg::MACHINE_PHASES);
	endfunction

	task check(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// Tick counts may land one above the estimate through the machine-cycle phase
	task rng(input logic [31:0] s, input logic [31:0] lo);
		check((s >= lo && s <= lo + 1) ? lo : s, lo);
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			n++;
		end while (!s_axi_bvalid && n < 200);
		s_axi_bready <= 1'h0;
		resp = s_axi_bresp;
		if (n >= 200) fail_count++;
	endtask

	task rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			n++;
		end while (!s_axi_rvalid && n < 200);
		s_axi_rready <= 1'h0;
		rv = s_axi_rdata;
		resp = s_axi_rresp;
		if (n >= 200) fail_count++;
	endtask

	task ld(input int ch, input logic [7:0] lo, input logic [7:0] hi);
		wr(ca(ch, 0), lo);
		wr(ca(ch, 1), hi);
	endtask

	// Run for w clocks, keep the flags, then stop
	task go(input logic [7:0] ctl, input int w);
		wr(TC, ctl);
		repeat (w) @(posedge aclk);
		rd(TC);
		cf = rv;
		wr(TC, 8'h00);
	endtask

	task final_report;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	initial begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end

	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		final_report;
	end

	// ==========================================================
	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		gate = 2'h0;
		aresetn = 1'h0;
		fail_count = 0;
		num_checks = 0;
		rnd = 32'h1E48;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			rd(TC + 12'(4 * i));
			check(rv, 32'h0);
		end
		// Unmapped place answers an error and reads zero
		wr(12'h300, 8'h5A);
		check({30'h0, resp}, {30'h0, dtc_pkg::RESP_SLVERR});
		rd(12'h300);
		check({30'h0, resp}, {30'h0, dtc_pkg::RESP_SLVERR});
		check(rv, 32'h0);
		// Random counter bytes written and read back
		repeat (8) begin
			rnd = lfsr(rnd);
			wr(C0L + 12'(4 * rnd[1:0]), rnd[15:8]);
			rd(C0L + 12'(4 * rnd[1:0]));
			check(rv, {24'h0, rnd[15:8]});
			check({30'h0, resp}, {30'h0, dtc_pkg::RESP_OKAY});
		end
		for (int ch = 0; ch < 2; ch++) begin
			oth = 1 - ch;
			rb = 8'h10 << (2 * ch);
			// Internal ticks, 16-bit mode, gate off, irq pin low
			ld(0, 8'h00, 8'h00);
			ld(1, 8'h00, 8'h00);
			wr(TM, 8'h01 << (4 * ch));
			go(rb, 120);
			rd(ca(ch, 0));
			rng(rv, ticks(120));
			rd(ca(oth, 0));
			check(rv, 32'h0);
			// Gated: pin low holds, pin high counts
			ld(ch, 8'h00, 8'h00);
			wr(TM, 8'h09 << (4 * ch));
			go(rb, 60);
			rd(ca(ch, 0));
			check(rv, 32'h0);
			gate[ch] <= 1'h1;
			go(rb, 60);
			gate[ch] <= 1'h0;
			rd(ca(ch, 0));
			rng(rv, ticks(60));
			// External falling edges on this counter's own pin
			ld(ch, 8'h00, 8'h00);
			wr(TM, 8'h05 << (4 * ch));
			wr(TC, rb);
			i_dtc_pin_model.pulses(ch, 5, 12 + 7 * ch);
			repeat (40) @(posedge aclk);
			rd(ca(ch, 0));
			check(rv, 32'h5);
			rd(ca(oth, 0));
			check(rv, 32'h0);
			wr(TC, 8'h00);
		end
		// 13-bit mode keeps low[7:5]; carry sets the flag
		ld(0, 8'hFF, 8'hFF);
		wr(TM, 8'h00);
		go(8'h10, 26);
		check(cf & 32'hA0, 32'h20);
		rd(ca(0, 1));
		check(rv, 32'h0);
		rd(ca(0, 0));
		rng(rv, 32'hE0 + ticks(26) - 32'h1);
		// Reload mode restarts the low byte from the high byte
		ld(0, 8'hFF, 8'h80);
		wr(TM, 8'h02);
		go(8'h10, 26);
		check(cf & 32'hA0, 32'h20);
		rd(ca(0, 0));
		rng(rv, 32'h80 + ticks(26) - 32'h1);
		rd(ca(0, 1));
		check(rv, 32'h80);
		// Split mode: high half under run_bit_one, counter 1 frozen
		ld(0, 8'h10, 8'hFF);
		ld(1, 8'h05, 8'h00);
		wr(TM, 8'h13);
		go(8'h40, 26);
		check(cf & 32'hA0, 32'h80);
		rd(ca(0, 0));
		check(rv, 32'h10);
		rd(ca(0, 1));
		rng(rv, ticks(26) - 32'h1);
		rd(ca(1, 0));
		check(rv, 32'h5);
		// Carry zero from 13-bit mode and carry one from the split half
		rd(IS);
		check(rv, 32'h3);
		// Power-down: pin edge counts directly and carry wakes
		for (int p = 1; p < 3; p++) begin
			wr(TM, 8'h05);
			ld(0, 8'hFF, 8'hFF);
			wr(IS, 8'h07);
			wr(IM, 8'h00);
			wr(TC, 8'h10);
			wr(PC, 8'(p));
			check({30'h0, hard_power_down, soft_power_down}, 32'(p));
			i_dtc_pin_model.pulses(0, 1, 12);
			repeat (20) @(posedge aclk);
			check({30'h0, hard_power_down, soft_power_down}, 32'h0);
			rd(PC);
			check(rv, 32'h0);
			rd(IS);
			check(rv, 32'h5);
			rd(ca(0, 0));
			check(rv, 32'h0);
			check({31'h0, irq}, 32'h0);
			wr(IM, 8'h04);
			repeat (2) @(posedge aclk);
			check({31'h0, irq}, 32'h1);
			wr(IS, 8'h04);
			repeat (2) @(posedge aclk);
			check({31'h0, irq}, 32'h0);
			wr(TC, 8'h00);
		end
		final_report;
	end
endmodule
